// File: fbm_axil_if.sv
// fbm_axil_if: decoded register access strobes between the slave and the monitor core
// assumes one clock, strobes last one cycle
`default_nettype none
interface fbm_axil_if;
    logic wr_en;
    logic [3:0] wr_addr;
    logic [31:0] wr_data;
    logic rd_en;
    logic [3:0] rd_addr;
    logic [31:0] rd_data;
    logic hit;
    modport slave (output wr_en, wr_addr, wr_data, rd_en, rd_addr, input rd_data, hit);
    modport core (input wr_en, wr_addr, wr_data, rd_en, rd_addr, output rd_data, hit);
endinterface
`default_nettype wire

// File: fbm_axil_slave.sv
// fbm_axil_slave: axi4-lite slave turning bus transfers into register strobes
// assumes the master follows axi4-lite; one write and one read at a time
`default_nettype none
module fbm_axil_slave
    import fbm_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [31:0] s_awaddr,
    input wire logic s_awvalid,
    output logic s_awready,
    input wire logic [31:0] s_wdata,
    input wire logic [3:0] s_wstrb,
    input wire logic s_wvalid,
    output logic s_wready,
    output logic [1:0] s_bresp,
    output logic s_bvalid,
    input wire logic s_bready,
    input wire logic [31:0] s_araddr,
    input wire logic s_arvalid,
    output logic s_arready,
    output logic [31:0] s_rdata,
    output logic [1:0] s_rresp,
    output logic s_rvalid,
    input wire logic s_rready,
    fbm_axil_if.slave rb
);
    logic aw_have_r, w_have_r, aw_oor_r;
    logic [3:0] aw_addr_r;
    logic [31:0] w_data_r;
    wire aw_take = s_awvalid && s_awready;
    wire w_take = s_wvalid && s_wready;
    wire ar_take = s_arvalid && s_arready;
    // hit is shared with the read decode, so a write waits out a read's take cycle
    wire do_write = aw_have_r && w_have_r && !s_bvalid && !ar_take;
    wire aligned_w = (aw_addr_r[1:0] == 2'b00);
    wire [3:0] ar_addr = s_araddr[3:0];
    wire ar_in_range = (s_araddr[31:4] == 28'h0000000) && (ar_addr[1:0] == 2'b00);
    // byte lanes ignored: every field sits in the low byte, partial writes land whole
    assign s_awready = !aw_have_r && !s_bvalid;
    assign s_wready = !w_have_r && !s_bvalid;
    assign s_arready = !s_rvalid;
    // out-of-range writes must not alias onto the low registers
    assign rb.wr_en = do_write && aligned_w && !aw_oor_r;
    assign rb.wr_addr = aw_addr_r;
    assign rb.wr_data = w_data_r;
    assign rb.rd_en = ar_take && ar_in_range;
    assign rb.rd_addr = ar_addr;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            aw_addr_r <= 4'h0;
            aw_oor_r <= 1'b0;
            w_data_r <= 32'h00000000;
            s_bvalid <= 1'b0;
            s_bresp <= RESP_OKAY;
        end else begin
            if (aw_take) begin
                aw_have_r <= 1'b1;
                aw_addr_r <= s_awaddr[3:0];
                aw_oor_r <= (s_awaddr[31:4] != 28'h0000000);
            end
            if (w_take) begin
                w_have_r <= 1'b1;
                w_data_r <= s_wdata;
            end
            if (do_write) begin
                aw_have_r <= 1'b0;
                w_have_r <= 1'b0;
                s_bvalid <= 1'b1;
                s_bresp <= (rb.hit && aligned_w && !aw_oor_r) ? RESP_OKAY : RESP_SLVERR;
            end else if (s_bvalid && s_bready) begin
                s_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_rvalid <= 1'b0;
            s_rdata <= 32'h00000000;
            s_rresp <= RESP_OKAY;
        end else if (ar_take) begin
            s_rvalid <= 1'b1;
            s_rdata <= ar_in_range ? rb.rd_data : 32'h00000000;
            s_rresp <= (ar_in_range && rb.hit) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_rvalid && s_rready) begin
            s_rvalid <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// File: fbm_monitor.sv
// fbm_monitor: bit-error monitor for a nonvolatile array, top module
// assumes error strobes come from the array read path on aclk, one cycle each;
// power_up_clear_reset goes to the system reset logic, which pulses aresetn back
//
// The implementer's own choices: the address map and register access over AXI4-Lite.
`default_nettype none
// Summary of operation
// - uncorrectable error with reset enable set fires the power-up-clear reset
// - a reset from an uncorrectable error leaves its code in the reset cause vector
// - uncorrectable error with its irq enable raises nmi and posts its nmi code
// - correctable error with its irq enable raises nmi and posts its nmi code
// - either error sets its flag in the flags register; otherwise it reads 0
// - both flags stay set until software clears each one by writing one
// - writing 0 to the power bit switches off the array supply regulator
module fbm_monitor
    import fbm_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [31:0] s_awaddr,
    input wire logic s_awvalid,
    output logic s_awready,
    input wire logic [31:0] s_wdata,
    input wire logic [3:0] s_wstrb,
    input wire logic s_wvalid,
    output logic s_wready,
    output logic [1:0] s_bresp,
    output logic s_bvalid,
    input wire logic s_bready,
    input wire logic [31:0] s_araddr,
    input wire logic s_arvalid,
    output logic s_arready,
    output logic [31:0] s_rdata,
    output logic [1:0] s_rresp,
    output logic s_rvalid,
    input wire logic s_rready,
    input wire logic rd_strobe,
    input wire logic corr_err,
    input wire logic uncorr_err,
    output logic array_power_on,
    output logic power_up_clear_reset,
    output logic nmi,
    output logic irq
);
    fbm_axil_if rb ();

    fbm_axil_slave u_slave (
        .aclk(aclk),
        .aresetn(aresetn),
        .s_awaddr(s_awaddr),
        .s_awvalid(s_awvalid),
        .s_awready(s_awready),
        .s_wdata(s_wdata),
        .s_wstrb(s_wstrb),
        .s_wvalid(s_wvalid),
        .s_wready(s_wready),
        .s_bresp(s_bresp),
        .s_bvalid(s_bvalid),
        .s_bready(s_bready),
        .s_araddr(s_araddr),
        .s_arvalid(s_arvalid),
        .s_arready(s_arready),
        .s_rdata(s_rdata),
        .s_rresp(s_rresp),
        .s_rvalid(s_rvalid),
        .s_rready(s_rready),
        .rb(rb)
    );

    logic [3:0] cfg_r;
    logic [1:0] flags_r;
    logic [7:0] rst_vec_r;
    logic [7:0] nmi_vec_r;
    logic [1:0] nmi_pend_r;
    logic puc_r;
    // the cause survives the reset it triggers, so it sits outside aresetn
    logic cause_valid_r;

    // errors only count on a read strobe
    wire ev_corr = rd_strobe && corr_err && !uncorr_err;
    wire ev_uncorr = rd_strobe && uncorr_err;
    wire wr_cfg = rb.wr_en && (rb.wr_addr == ADDR_CONFIG);
    wire wr_flags = rb.wr_en && (rb.wr_addr == ADDR_FLAGS);
    wire rd_rst = rb.rd_en && (rb.rd_addr == ADDR_RST_VEC);
    wire rd_nmi = rb.rd_en && (rb.rd_addr == ADDR_NMI_VEC);
    wire [1:0] flag_set = {ev_uncorr, ev_corr};
    wire [1:0] flag_clr = wr_flags ? rb.wr_data[1:0] : 2'b00;
    wire fire_puc = ev_uncorr && cfg_r[CFG_URST];
    wire fire_unmi = ev_uncorr && cfg_r[CFG_UIE];
    wire fire_cnmi = ev_corr && cfg_r[CFG_CIE];
    wire [1:0] nmi_set = {fire_unmi, fire_cnmi};
    // reading the nmi vector acknowledges the highest pending source
    wire [1:0] nmi_ack = !rd_nmi ? 2'b00 :
        nmi_pend_r[FLG_UNCORR] ? 2'b10 : nmi_pend_r[FLG_CORR] ? 2'b01 : 2'b00;
    wire [1:0] nmi_pend_nxt = (nmi_pend_r & ~nmi_ack) | nmi_set;
    wire [7:0] nmi_vec_nxt = nmi_pend_nxt[FLG_UNCORR] ? NMI_VEC_UNCORR :
        nmi_pend_nxt[FLG_CORR] ? NMI_VEC_CORR : VEC_NONE;

    assign rb.hit = rb.wr_en ? (wr_cfg || wr_flags) :
        (rb.rd_addr == ADDR_CONFIG) || (rb.rd_addr == ADDR_FLAGS) ||
        (rb.rd_addr == ADDR_RST_VEC) || (rb.rd_addr == ADDR_NMI_VEC);
    assign rb.rd_data = (rb.rd_addr == ADDR_CONFIG) ? {28'h0000000, cfg_r} :
        (rb.rd_addr == ADDR_FLAGS) ? {30'h0, flags_r} :
        (rb.rd_addr == ADDR_RST_VEC) ? {24'h000000, rst_vec_r} :
        (rb.rd_addr == ADDR_NMI_VEC) ? {24'h000000, nmi_vec_r} : 32'h00000000;

    assign array_power_on = cfg_r[CFG_PWR];
    assign power_up_clear_reset = puc_r;
    assign nmi = |nmi_pend_r;
    // flags register doubles as status, config enables as mask
    assign irq = (flags_r[FLG_CORR] && cfg_r[CFG_CIE]) ||
        (flags_r[FLG_UNCORR] && cfg_r[CFG_UIE]);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cfg_r <= CFG_RESET;
        end else if (wr_cfg) begin
            cfg_r <= rb.wr_data[3:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flags_r <= 2'b00;
        end else begin
            // set beats a simultaneous clear
            flags_r <= (flags_r & ~flag_clr) | flag_set;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            nmi_pend_r <= 2'b00;
            nmi_vec_r <= VEC_NONE;
        end else begin
            nmi_pend_r <= nmi_pend_nxt;
            nmi_vec_r <= nmi_vec_nxt;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            puc_r <= 1'b0;
        end else begin
            puc_r <= fire_puc;
        end
    end

    // reset cause: latched when fired, shown after the reset, cleared by reading it
    always_ff @(posedge aclk) begin
        if (fire_puc) begin
            cause_valid_r <= 1'b1;
        end else if (rd_rst && aresetn) begin
            cause_valid_r <= 1'b0;
        end else if (cause_valid_r !== 1'b1) begin
            cause_valid_r <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rst_vec_r <= cause_valid_r ? RST_VEC_UNCORR : VEC_NONE;
        end else if (fire_puc) begin
            rst_vec_r <= RST_VEC_UNCORR;
        end else if (rd_rst) begin
            rst_vec_r <= VEC_NONE;
        end
    end
endmodule
`default_nettype wire

// File: fbm_monitor_asserts.sv
// fbm_monitor_asserts: port-level checks on the bit-error monitor
// assumes the single aclk domain, bound to every fbm_monitor
`default_nettype none
module fbm_monitor_asserts
    import fbm_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_bvalid,
    input wire logic s_bready,
    input wire logic [31:0] s_rdata,
    input wire logic [1:0] s_rresp,
    input wire logic s_rvalid,
    input wire logic s_rready,
    input wire logic rd_strobe,
    input wire logic corr_err,
    input wire logic uncorr_err,
    input wire logic array_power_on,
    input wire logic power_up_clear_reset,
    input wire logic nmi,
    input wire logic irq
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_err_rd;
        rd_strobe && (corr_err || uncorr_err);
    endsequence
    sequence s_wr_ack;
        $rose(s_bvalid);
    endsequence
    property p_puc_cause;
        power_up_clear_reset |-> $past(rd_strobe && uncorr_err);
    endproperty
    a_puc_cause: assert property (p_puc_cause) else $error("reset pulse w/o error");
    property p_puc_once;
        s_err_rd ##1 (power_up_clear_reset && !(rd_strobe && uncorr_err))
            |=> !power_up_clear_reset;
    endproperty
    a_puc_once: assert property (p_puc_once) else $error("reset pulse too long");
    property p_nmi_cause;
        $rose(nmi) |-> $past(rd_strobe && (corr_err || uncorr_err));
    endproperty
    a_nmi_cause: assert property (p_nmi_cause) else $error("nmi w/o error");
    property p_irq;
        $rose(nmi) && !$rose(s_bvalid) |-> irq;
    endproperty
    a_irq: assert property (p_irq) else $error("irq not with nmi");
    property p_pwr;
        $changed(array_power_on) |-> s_wr_ack;
    endproperty
    a_pwr: assert property (p_pwr) else $error("power bit moved w/o write");
    property p_b_hold;
        s_bvalid && !s_bready |=> s_bvalid;
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
    property p_b_done;
        s_bvalid && s_bready |=> !s_bvalid;
    endproperty
    a_b_done: assert property (p_b_done) else $error("write answer repeated");
    property p_r_done;
        s_rvalid && s_rready |=> !s_rvalid;
    endproperty
    a_r_done: assert property (p_r_done) else $error("read answer repeated");
    property p_r_hold;
        s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata);
    endproperty
    a_r_hold: assert property (p_r_hold) else $error("read answer moved");
    property p_err_data;
        s_rvalid && s_rresp == RESP_SLVERR |-> s_rdata == 32'h0;
    endproperty
    a_err_data: assert property (p_err_data) else $error("error read not zero");
endmodule
bind fbm_monitor fbm_monitor_asserts u_chk (.aclk, .aresetn, .s_bvalid, .s_bready, .s_rdata,
    .s_rresp, .s_rvalid, .s_rready, .rd_strobe, .corr_err, .uncorr_err, .array_power_on,
    .power_up_clear_reset, .nmi, .irq);
`default_nettype wire

// File: fbm_monitor_tb.sv
// fbm_monitor_tb: self-checking bench, bus and error strobes driven here
// assumes the checker binds itself; power_up_clear_reset is not looped back
`default_nettype none
module fbm_monitor_tb
    import fbm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk = 1'b0;
    logic aresetn, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready, rd_strobe;
    logic corr_err, uncorr_err, s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
    logic array_power_on, power_up_clear_reset, nmi, irq;
    logic [31:0] s_awaddr, s_wdata, s_araddr, s_rdata;
    logic [3:0] s_wstrb;
    logic [1:0] s_bresp, s_rresp;
    logic [33:0] exp_q[$];
    int fail_count, comparisons;
    fbm_monitor dut (.aclk, .aresetn, .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb,
        .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid,
        .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready, .rd_strobe, .corr_err,
        .uncorr_err, .array_power_on, .power_up_clear_reset, .nmi, .irq);
    always #2 aclk = ~aclk;
    task automatic fail(input string m);
        fail_count++;
        $display("unexpected %0t %s", $time, m);
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) fail($sformatf("port %h want %h", g, e));
    endtask
    task automatic cmp_rd(input logic [33:0] g, input logic [33:0] e);
        comparisons++;
        if (g !== e) fail($sformatf("read %h want %h", g, e));
    endtask
    task automatic report_and_stop;
        $display("fail_count %0d comparisons %0d", fail_count, comparisons);
        if (fail_count == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // response ready goes up with the request and stays up between transfers
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        s_awaddr <= {24'h0, a};
        s_wdata <= d;
        s_awvalid <= 1'b1;
        s_wvalid <= 1'b1;
        s_bready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (s_awready) s_awvalid <= 1'b0;
            if (s_wready) s_wvalid <= 1'b0;
            if (s_bvalid) break;
        end
        chk(32'(s_bresp), 32'(r));
    endtask
    task automatic rd(input logic [7:0] a, input logic [33:0] e);
        exp_q.push_back(e);
        s_araddr <= {24'h0, a};
        s_arvalid <= 1'b1;
        s_rready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (s_arready) s_arvalid <= 1'b0;
            if (s_rvalid) break;
        end
    endtask
    always @(posedge aclk) if (s_rvalid && s_rready) cmp_rd({s_rresp, s_rdata}, exp_q.pop_front());
    // qualifiers go random while the strobe is low; they must be ignored
    task automatic err(input logic c, input logic u, input logic n, input logic p);
        rd_strobe <= 1'b1;
        corr_err <= c;
        uncorr_err <= u;
        @(posedge aclk);
        rd_strobe <= 1'b0;
        corr_err <= 1'($urandom);
        uncorr_err <= 1'($urandom);
        // the reset pulse stands for one cycle only
        @(posedge aclk);
        chk(32'(nmi), 32'(n));
        chk(32'(irq), 32'(n));
        chk(32'(power_up_clear_reset), 32'(p));
    endtask
    task automatic rst;
        aresetn <= 1'b0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
    endtask
    initial begin
        repeat (3000) @(posedge aclk);
        fail("watchdog");
        report_and_stop;
    end
    initial begin
        void'($urandom(32'h8c2771ba));
        {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready, rd_strobe} <= 6'h0;
        {corr_err, uncorr_err, s_awaddr, s_wdata, s_araddr} <= 98'h0;
        s_wstrb <= 4'hf;
        rst;
        rd({4'h0, ADDR_CONFIG}, {RESP_OKAY, 28'h0, CFG_RESET});
        rd({4'h0, ADDR_FLAGS}, 34'h0);
        rd(8'h10, {RESP_SLVERR, 32'h0});
        wr({4'h0, ADDR_NMI_VEC}, $urandom, RESP_SLVERR);
        wr(8'h10, 32'h0, RESP_SLVERR);
        rd({4'h0, ADDR_CONFIG}, {RESP_OKAY, 28'h0, CFG_RESET});
        wr({4'h0, ADDR_CONFIG}, 32'h1, RESP_OKAY);
        err(1'b1, 1'b0, 1'b0, 1'b0);
        err(1'b0, 1'b1, 1'b0, 1'b0);
        rd({4'h0, ADDR_FLAGS}, {RESP_OKAY, 32'h3});
        wr({4'h0, ADDR_FLAGS}, 32'h1, RESP_OKAY);
        rd({4'h0, ADDR_FLAGS}, {RESP_OKAY, 32'h2});
        wr({4'h0, ADDR_FLAGS}, 32'h2, RESP_OKAY);
        rd({4'h0, ADDR_FLAGS}, {RESP_OKAY, 32'h0});
        wr({4'h0, ADDR_CONFIG}, 32'h9, RESP_OKAY);
        err(1'b1, 1'b0, 1'b1, 1'b0);
        rd({4'h0, ADDR_NMI_VEC}, {RESP_OKAY, 24'h0, NMI_VEC_CORR});
        chk(32'(irq), 32'h1);
        wr({4'h0, ADDR_CONFIG}, 32'h5, RESP_OKAY);
        chk(32'(nmi), 32'h0);
        chk(32'(irq), 32'h0);
        err(1'b0, 1'b1, 1'b1, 1'b0);
        rd({4'h0, ADDR_NMI_VEC}, {RESP_OKAY, 24'h0, NMI_VEC_UNCORR});
        wr({4'h0, ADDR_CONFIG}, 32'h3, RESP_OKAY);
        chk(32'(nmi), 32'h0);
        err(1'b0, 1'b1, 1'b0, 1'b1);
        rst;
        rd({4'h0, ADDR_RST_VEC}, {RESP_OKAY, 24'h0, RST_VEC_UNCORR});
        rd({4'h0, ADDR_RST_VEC}, {RESP_OKAY, 32'h0});
        wr({4'h0, ADDR_CONFIG}, 32'h0, RESP_OKAY);
        chk(32'(array_power_on), 32'h0);
        report_and_stop;
    end
endmodule
`default_nettype wire

// File: fbm_pkg.sv
// fbm_pkg: register map, field positions, reset values and codes for the monitor
// assumes a 32-bit axi4-lite slave and a single 250 MHz clock
`default_nettype none
package fbm_pkg;
    localparam logic [3:0] ADDR_CONFIG = 4'h0;
    localparam logic [3:0] ADDR_FLAGS = 4'h4;
    localparam logic [3:0] ADDR_RST_VEC = 4'h8;
    localparam logic [3:0] ADDR_NMI_VEC = 4'hc;
    // config fields
    localparam int CFG_PWR = 0;
    localparam int CFG_URST = 1;
    localparam int CFG_UIE = 2;
    localparam int CFG_CIE = 3;
    localparam logic [3:0] CFG_RESET = 4'h1;
    // flag fields
    localparam int FLG_CORR = 0;
    localparam int FLG_UNCORR = 1;
    // vector codes, arbitrary values
    localparam logic [7:0] VEC_NONE = 8'h00;
    localparam logic [7:0] RST_VEC_UNCORR = 8'h1a;
    localparam logic [7:0] NMI_VEC_UNCORR = 8'h02;
    localparam logic [7:0] NMI_VEC_CORR = 8'h04;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage
`default_nettype wire
